// >>> inc/fwx_if.sv
`timescale 1ns/1ps
interface fwx_if;
    import fwx_pkg::*;
    fwx_word_t host_write_data_word;
    fwx_word_t host_control_word;
    fwx_word_t unit_read_data_word;
    fwx_word_t unit_status_word;
    modport unit (
        input host_write_data_word,
        input host_control_word,
        output unit_read_data_word,
        output unit_status_word
    );
    modport host (
        output host_write_data_word,
        output host_control_word,
        input unit_read_data_word,
        input unit_status_word
    );
endinterface

// >>> inc/fwx_map.svh
`ifndef FWX_MAP_SVH
`define FWX_MAP_SVH
// Word offsets inside the io_word_area
`define FWX_OFF_WDATA 2'h0
`define FWX_OFF_CTRL 2'h1
`define FWX_OFF_RDATA 2'h2
`define FWX_OFF_STAT 2'h3
// Control word fields
`define FWX_CTL_PT_LSB 0
`define FWX_CTL_PT_MSB 7
`define FWX_CTL_NORMAL 8
`define FWX_CTL_PKRST 12
`define FWX_CTL_CONV 13
`define FWX_CTL_WROTE 14
`define FWX_CTL_TOOK 15
// Command bits copied straight into the control word: points, normal, peak reset, conversion
`define FWX_CTL_COPY 16'h31FF
// Status word fields
`define FWX_ST_PT_LSB 0
`define FWX_ST_PT_MSB 7
`define FWX_ST_OPEN 8
`define FWX_ST_NORMAL 9
`define FWX_ST_ACCEPT 14
`define FWX_ST_VALID 15
// Host register offsets (controller side)
`define FWX_H_CMD 3'h0
`define FWX_H_WDATA 3'h1
`define FWX_H_RDATA 3'h2
`define FWX_H_STAT 3'h3
`define FWX_H_IRQ 3'h4
`define FWX_H_MASK 3'h5
// Host command fields
`define FWX_CMD_GO 15
`define FWX_CMD_WRITE 14
`define FWX_CMD_PKRST 12
// Timing
`define FWX_AVG_MS 10
`define FWX_CLK_MHZ 100
`define FWX_CLK_PER_MS (`FWX_CLK_MHZ * 1000)
`define FWX_AVG_CYC (`FWX_AVG_MS * `FWX_CLK_PER_MS)
`endif

// >>> inc/fwx_pkg.sv
package fwx_pkg;
    typedef logic [15:0] fwx_word_t;
    typedef logic [7:0] fwx_sel_t;
    typedef enum logic [3:0] {
        FWX_D_IDLE = 4'h1,
        FWX_D_ACK = 4'h2,
        FWX_D_WAIT = 4'h4,
        FWX_D_SHOW = 4'h8
    } fwx_dev_st_t;
    typedef enum logic [2:0] {
        FWX_H_IDLE = 3'h1,
        FWX_H_BUSY = 3'h2,
        FWX_H_DONE = 3'h4
    } fwx_host_st_t;
endpackage

// >>> logic/fwx_host.sv
`timescale 1ns/1ps
`include "fwx_map.svh"
module fwx_host
    import fwx_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Software port
    input wire logic [2:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic irq,
    // Link to unit
    fwx_if.host link
);
    import fwx_pkg::*;

    fwx_host_st_t st_reg, st_next;
    fwx_word_t cmd_reg, cmd_next;
    fwx_word_t wd_reg, wd_next;
    fwx_word_t ctl_reg, ctl_next;
    fwx_word_t got_reg, got_next;
    fwx_word_t gst_reg, gst_next;
    logic [1:0] irq_reg, irq_next;
    logic [1:0] mask_reg, mask_next;
    fwx_word_t rdata_reg, rdata_next;
    logic [1:0] ev;
    fwx_word_t st_in;

    assign st_in = link.unit_status_word;

    always_comb begin
        st_next = st_reg;
        cmd_next = cmd_reg;
        wd_next = wd_reg;
        ctl_next = ctl_reg;
        got_next = got_reg;
        gst_next = gst_reg;
        mask_next = mask_reg;
        rdata_next = 16'h0;
        ev = 2'b00;
        if (wr && addr == `FWX_H_WDATA) begin
            wd_next = wdata;
        end
        if (wr && addr == `FWX_H_MASK) begin
            mask_next = wdata[1:0];
        end
        case (st_reg)
            FWX_H_IDLE: begin
                // Software command: bits 7..0 point (one-hot), 8 normal, 13 conv
                if (wr && addr == `FWX_H_CMD && wdata[`FWX_CMD_GO]) begin
                    cmd_next = wdata;
                    ctl_next = wdata & `FWX_CTL_COPY;
                    ctl_next[`FWX_CTL_WROTE] = wdata[`FWX_CMD_WRITE];
                    st_next = FWX_H_BUSY;
                end
            end
            FWX_H_BUSY: begin
                if (cmd_reg[`FWX_CMD_WRITE] && st_in[`FWX_ST_ACCEPT]) begin
                    // Point bits drop too, or the unit takes a lingering designation as a peak read
                    ctl_next = 16'h0;
                    ev[0] = 1'b1;
                    st_next = FWX_H_DONE;
                end else if (!cmd_reg[`FWX_CMD_WRITE] && st_in[`FWX_ST_VALID]) begin
                    got_next = link.unit_read_data_word;
                    gst_next = st_in;
                    ctl_next[`FWX_CTL_TOOK] = 1'b1;
                    ctl_next[`FWX_CTL_PKRST] = 1'b0;
                    ev[1] = 1'b1;
                    st_next = FWX_H_DONE;
                end
            end
            FWX_H_DONE: begin
                ctl_next[`FWX_CTL_TOOK] = 1'b0;
                if (!st_in[`FWX_ST_ACCEPT] && !st_in[`FWX_ST_VALID]) begin
                    ctl_next = 16'h0;
                    st_next = FWX_H_IDLE;
                end
            end
            default: begin
                st_next = FWX_H_IDLE;
            end
        endcase
        // Set wins over write-one-to-clear
        irq_next = (irq_reg & ~((wr && addr == `FWX_H_IRQ) ? wdata[1:0] : 2'b00)) | ev;
        if (rd) begin
            case (addr)
                `FWX_H_CMD: rdata_next = cmd_reg;
                `FWX_H_WDATA: rdata_next = wd_reg;
                `FWX_H_RDATA: rdata_next = got_reg;
                `FWX_H_STAT: rdata_next = gst_reg;
                `FWX_H_IRQ: rdata_next = {14'h0, irq_reg};
                `FWX_H_MASK: rdata_next = {14'h0, mask_reg};
                default: rdata_next = {13'h0, st_reg};
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg <= FWX_H_IDLE;
            cmd_reg <= 16'h0;
            wd_reg <= 16'h0;
            ctl_reg <= 16'h0;
            got_reg <= 16'h0;
            gst_reg <= 16'h0;
            irq_reg <= 2'b00;
            mask_reg <= 2'b00;
            rdata_reg <= 16'h0;
        end else begin
            st_reg <= st_next;
            cmd_reg <= cmd_next;
            wd_reg <= wd_next;
            ctl_reg <= ctl_next;
            got_reg <= got_next;
            gst_reg <= gst_next;
            irq_reg <= irq_next;
            mask_reg <= mask_next;
            rdata_reg <= rdata_next;
        end
    end

    assign link.host_write_data_word = wd_reg;
    assign link.host_control_word = ctl_reg;
    assign rdata = rdata_reg;
    assign irq = |(irq_reg & mask_reg);
endmodule // fwx_host

// >>> logic/fwx_point_avg.sv
`timescale 1ns/1ps
`include "fwx_map.svh"
module fwx_point_avg
    import fwx_pkg::*;
#(
    parameter int AVG_CYC = `FWX_AVG_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic [15:0] count,
    input wire logic [15:0] sample,
    // Result
    output logic [15:0] mean,
    output logic ready
);
    logic [31:0] tick_reg, tick_next;
    logic [15:0] left_reg, left_next;
    logic [31:0] sum_reg, sum_next;
    logic [15:0] mean_reg, mean_next;
    logic ready_reg, ready_next;

    always_comb begin
        tick_next = tick_reg;
        left_next = left_reg;
        sum_next = sum_reg;
        mean_next = mean_reg;
        ready_next = ready_reg;
        if (start) begin
            // Averaging begins only when the point is designated
            left_next = count;
            sum_next = 32'h0;
            tick_next = 32'h0;
            ready_next = (count == 16'h0);
            mean_next = sample;
        end else if (count == 16'h0) begin
            mean_next = sample;
            ready_next = 1'b1;
        end else if (left_reg != 16'h0) begin
            if (tick_reg == 32'(AVG_CYC - 1)) begin
                tick_next = 32'h0;
                sum_next = sum_reg + 32'(sample);
                left_next = left_reg - 16'h1;
                if (left_reg == 16'h1) begin
                    // Ready after 10 ms per sample
                    mean_next = 16'((sum_reg + 32'(sample)) / 32'(count));
                    ready_next = 1'b1;
                end
            end else begin
                tick_next = tick_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tick_reg <= 32'h0;
            left_reg <= 16'h0;
            sum_reg <= 32'h0;
            mean_reg <= 16'h0;
            ready_reg <= 1'b0;
        end else begin
            tick_reg <= tick_next;
            left_reg <= left_next;
            sum_reg <= sum_next;
            mean_reg <= mean_next;
            ready_reg <= ready_next;
        end
    end

    assign mean = mean_reg;
    assign ready = ready_reg;
endmodule // fwx_point_avg

// >>> logic/fwx_unit.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "fwx_map.svh"
module fwx_unit
    import fwx_pkg::*;
#(
    parameter int POINTS = 8,
    parameter int AVG_CYC = `FWX_AVG_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Link to host
    fwx_if.unit link,
    // Analog side: one converted sample per point, plus open-line pins
    input wire logic [POINTS*16-1:0] sample_in,
    input wire logic [POINTS-1:0] open_in,
    // Sample counts as currently configured
    output logic [POINTS*16-1:0] avg_count
);
    import fwx_pkg::*;

    ////////////////////////////////////////////////////////////////////
    fwx_dev_st_t st_reg, st_next;
    fwx_word_t rdata_reg, rdata_next;
    fwx_word_t stat_reg, stat_next;
    logic [15:0] cnt_reg [POINTS];
    logic [15:0] cnt_next [POINTS];
    logic [15:0] peak_reg [POINTS];
    logic [15:0] peak_next [POINTS];
    logic [POINTS-1:0] peak_flag_reg, peak_flag_next;
    logic pkrst_prev_reg;
    fwx_sel_t sel_prev_reg;
    logic [POINTS-1:0] open_s1_reg, open_s2_reg;
    logic [POINTS*16-1:0] samp_s1_reg, samp_s2_reg;
    logic [15:0] mean [POINTS];
    logic [POINTS-1:0] mean_ok;
    logic [POINTS-1:0] start;
    fwx_word_t ctrl;
    fwx_sel_t sel;
    int idx;

    // Sampled host words come from the same clock, so no synchroniser
    assign ctrl = link.host_control_word;
    assign sel = ctrl[`FWX_CTL_PT_MSB:`FWX_CTL_PT_LSB];

    always_comb begin
        idx = 0;
        for (int i = 0; i < POINTS; i++) begin
            if (sel[i]) begin
                idx = i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Averaging per point; a new designation restarts that point
    genvar g;
    generate
        for (g = 0; g < POINTS; g++) begin : g_avg
            assign start[g] = sel[g] & ~sel_prev_reg[g];
            fwx_point_avg #(.AVG_CYC(AVG_CYC)) u_avg (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .start(start[g]),
                .count(cnt_reg[g]),
                .sample(samp_s2_reg[g*16 +: 16]),
                .mean(mean[g]),
                .ready(mean_ok[g])
            );
            assign avg_count[g*16 +: 16] = cnt_reg[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        rdata_next = rdata_reg;
        stat_next = stat_reg;
        cnt_next = cnt_reg;
        peak_next = peak_reg;
        peak_flag_next = peak_flag_reg;
        // Peak tracking; a flagged peak is frozen until read out
        for (int i = 0; i < POINTS; i++) begin
            if (!peak_flag_reg[i] && samp_s2_reg[i*16 +: 16] > peak_reg[i]) begin
                peak_next[i] = samp_s2_reg[i*16 +: 16];
                peak_flag_next[i] = 1'b1;
            end
        end
        // Falling peak reset clears the selected point
        if (pkrst_prev_reg && !ctrl[`FWX_CTL_PKRST]) begin
            peak_next[idx] = 16'h0;
            peak_flag_next[idx] = 1'b0;
        end
        case (st_reg)
            FWX_D_IDLE: begin
                if (ctrl[`FWX_CTL_WROTE] && !ctrl[`FWX_CTL_CONV] && sel != 8'h0) begin
                    // Write data taken as sample count of the designated point
                    cnt_next[idx] = link.host_write_data_word;
                    stat_next[`FWX_ST_ACCEPT] = 1'b1;
                    st_next = FWX_D_ACK;
                end else if (sel != 8'h0 && !ctrl[`FWX_CTL_TOOK] && !start[idx]
                             && (!ctrl[`FWX_CTL_CONV] || mean_ok[idx])) begin
                    // Ready is ignored in the restart cycle: it still belongs to the old average
                    st_next = FWX_D_SHOW;
                end
            end
            FWX_D_ACK: begin
                // Acknowledge stands until the host drops its bit
                if (!ctrl[`FWX_CTL_WROTE]) begin
                    stat_next[`FWX_ST_ACCEPT] = 1'b0;
                    st_next = FWX_D_IDLE;
                end
            end
            FWX_D_SHOW: begin
                if (ctrl[`FWX_CTL_CONV]) begin
                    rdata_next = mean[idx];
                    stat_next[`FWX_ST_NORMAL] = 1'b1;
                end else begin
                    rdata_next = peak_reg[idx];
                    stat_next[`FWX_ST_NORMAL] = 1'b0;
                    peak_flag_next[idx] = 1'b0;
                end
                stat_next[`FWX_ST_PT_MSB:`FWX_ST_PT_LSB] = 8'(1 << idx);
                stat_next[`FWX_ST_OPEN] = open_s2_reg[idx];
                stat_next[`FWX_ST_VALID] = 1'b1;
                st_next = FWX_D_WAIT;
            end
            FWX_D_WAIT: begin
                // Data flag held until host reports the word taken and drops it
                if (ctrl[`FWX_CTL_TOOK]) begin
                    stat_next[`FWX_ST_VALID] = 1'b0;
                end
                if (!ctrl[`FWX_CTL_TOOK] && !stat_reg[`FWX_ST_VALID]) begin
                    st_next = FWX_D_IDLE;
                end
            end
            default: begin
                st_next = FWX_D_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_reg <= FWX_D_IDLE;
            rdata_reg <= 16'h0;
            stat_reg <= 16'h0;
            peak_flag_reg <= '0;
            pkrst_prev_reg <= 1'b0;
            sel_prev_reg <= 8'h0;
            open_s1_reg <= '0;
            open_s2_reg <= '0;
            samp_s1_reg <= '0;
            samp_s2_reg <= '0;
            for (int i = 0; i < POINTS; i++) begin
                cnt_reg[i] <= 16'h0;
                peak_reg[i] <= 16'h0;
            end
        end else begin
            st_reg <= st_next;
            rdata_reg <= rdata_next;
            stat_reg <= stat_next;
            peak_flag_reg <= peak_flag_next;
            pkrst_prev_reg <= ctrl[`FWX_CTL_PKRST];
            sel_prev_reg <= sel;
            open_s1_reg <= open_in;
            open_s2_reg <= open_s1_reg;
            samp_s1_reg <= sample_in;
            samp_s2_reg <= samp_s1_reg;
            cnt_reg <= cnt_next;
            peak_reg <= peak_next;
        end
    end

    assign link.unit_read_data_word = rdata_reg;
    assign link.unit_status_word = stat_reg;
endmodule // fwx_unit

// >>> verification/fwx_link_monitor.sv
`timescale 1ns/1ps
module fwx_link_monitor
    import fwx_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Link words
    input wire fwx_pkg::fwx_word_t host_write_data_word,
    input wire fwx_pkg::fwx_word_t host_control_word,
    input wire fwx_pkg::fwx_word_t unit_read_data_word,
    input wire fwx_pkg::fwx_word_t unit_status_word
);
    logic [15:0] c;
    logic [15:0] s;
    assign c = host_control_word;
    assign s = unit_status_word;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    accept_cause_a: assert property ($rose(s[14]) |-> c[14] && !c[13] && $onehot(c[7:0]))
        else $error("write accepted without a valid write request");
    accept_hold_a: assert property (s[14] && c[14] |=> s[14])
        else $error("accept flag dropped before host bit");
    accept_drop_a: assert property ($fell(c[14]) |-> ##[1:4] !s[14])
        else $error("accept flag stuck after host bit dropped");
    host_answer_a: assert property ($rose(s[14]) |-> ##[1:4] !c[14])
        else $error("host kept write bit after acceptance");
    wdata_hold_a: assert property (c[14] && !s[14] |=> $stable(host_write_data_word))
        else $error("write data moved before acceptance");
    point_onehot_a: assert property ($onehot0(c[7:0]))
        else $error("more than one point selected");
    valid_point_a: assert property ($rose(s[15]) |-> s[7:0] == c[7:0] && $onehot(s[7:0]))
        else $error("presented point does not match selection");
    valid_type_a: assert property ($rose(s[15]) |-> s[9] == (c[13] && c[8]))
        else $error("data type flag wrong");
    valid_hold_a: assert property (s[15] && !c[15] |=> s[15] && $stable(unit_read_data_word))
        else $error("read data not held until taken");
    ////////////////////////////////////////////////////////////////////////
    cover property ($rose(s[14]));
    cover property ($rose(s[15]) && s[9]);
    cover property ($rose(s[15]) && !s[9]);
    cover property ($rose(s[15]) && s[8]);
endmodule // fwx_link_monitor

// >>> verification/tb_four_word_analog_input_exchange.sv
`timescale 1ns/1ps
`include "fwx_map.svh"
module tb_four_word_analog_input_exchange;
    import fwx_pkg::*;
    // Short averaging period keeps the run brief
    localparam int AVG = 10;
    logic clk_sys;
    logic nrst;
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic irq;
    logic [127:0] sample_in;
    logic [127:0] avg_count;
    logic [7:0] open_in;
    logic [15:0] v;
    int error_cnt;
    int num_checks;
    int cyc;
    int cnt[8];
    int smp[8];
    fwx_if link_if();
    fwx_unit #(.POINTS(8), .AVG_CYC(AVG)) i_fwx_unit (.clk_sys(clk_sys), .nrst(nrst), .link(link_if),
        .sample_in(sample_in), .open_in(open_in), .avg_count(avg_count));
    fwx_host i_fwx_host (.clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .link(link_if));
    fwx_link_monitor mon (.clk_sys(clk_sys), .nrst(nrst), .host_write_data_word(link_if.host_write_data_word),
        .host_control_word(link_if.host_control_word), .unit_read_data_word(link_if.unit_read_data_word),
        .unit_status_word(link_if.unit_status_word));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end
    task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp=%h seen=%h", n, exp, seen);
        end
    endtask
    task end_of_test();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task wreg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk_sys);
        wr <= 1'h0;
    endtask
    task rreg(input logic [2:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk_sys);
        rd <= 1'h0;
        #1 v = rdata;
    endtask
    // Command, timed wait for the event, then acknowledge and wait for idle
    task xfer(input logic [15:0] cmd, input logic [15:0] ibit);
        int k;
        wreg(`FWX_H_CMD, cmd);
        cyc = 0;
        while (irq !== 1'h1 && cyc < 3000) begin
            @(posedge clk_sys);
            #1;
            cyc++;
        end
        chk("irq", {15'h0, irq}, 16'h0001);
        rreg(`FWX_H_IRQ);
        chk("irq_stat", v, ibit);
        wreg(`FWX_H_IRQ, ibit);
        rreg(`FWX_H_IRQ);
        chk("irq_clr", v, 16'h0000);
        k = 0;
        while ((link_if.host_control_word !== 16'h0000 || link_if.unit_status_word[15:14] !== 2'h0) && k < 50) begin
            @(posedge clk_sys);
            k++;
        end
        chk("idle", {link_if.unit_status_word[15:14], link_if.host_control_word[13:0]}, 16'h0000);
    endtask
    task settle_sample(input int p, input int val);
        sample_in[p*16+:16] <= 16'(val);
        repeat (3 * AVG) @(posedge clk_sys);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        nrst = 1'h0;
        wr = 1'h0;
        rd = 1'h0;
        addr = 3'h0;
        wdata = 16'h0000;
        sample_in = '0;
        error_cnt = 0;
        num_checks = 0;
        void'($urandom(74));
        open_in = 8'($urandom);
        repeat (12) @(posedge clk_sys);
        nrst <= 1'h1;
        wreg(`FWX_H_MASK, 16'h0003);
        // Point 0 stays unaveraged so it can serve the peak scenario
        for (int p = 0; p < 8; p++) begin
            cnt[p] = (p == 0) ? 0 : 1 + $urandom % 5;
            wreg(`FWX_H_WDATA, 16'(cnt[p]));
            xfer(16'hC000 | (16'h0001 << p), 16'h0001);
            chk("avg_count", avg_count[p*16+:16], 16'(cnt[p]));
        end
        // Samples held steady, so any mean equals the sample
        for (int p = 0; p < 8; p++) begin
            smp[p] = $urandom & 32'h7FFF;
            settle_sample(p, smp[p]);
            xfer(16'hA100 | (16'h0001 << p), 16'h0002);
            chk("avg_time", 16'(cyc + 2 >= cnt[p] * AVG && cyc <= cnt[p] * AVG + 8), 16'h0001);
            rreg(`FWX_H_RDATA);
            chk("rdata", v, 16'(smp[p]));
            rreg(`FWX_H_STAT);
            chk("point", {8'h00, v[7:0]}, 16'h0001 << p);
            chk("open", {15'h0, v[8]}, {15'h0, open_in[p]});
            chk("normal", {15'h0, v[9]}, 16'h0001);
        end
        // Peak of point 0: clear the frozen peak at a zero sample, then a high sample and a lower one
        settle_sample(0, 32'h0000);
        xfer(16'h9001, 16'h0002);
        settle_sample(0, 32'h7FFF);
        settle_sample(0, 32'h0010);
        for (int r = 0; r < 2; r++) begin
            xfer(16'h8001, 16'h0002);
            rreg(`FWX_H_RDATA);
            chk("peak", v, 16'h7FFF);
            rreg(`FWX_H_STAT);
            chk("peak_type", {15'h0, v[9]}, 16'h0000);
        end
        xfer(16'h9001, 16'h0002);
        settle_sample(0, 32'h0010);
        xfer(16'h8001, 16'h0002);
        rreg(`FWX_H_RDATA);
        chk("peak_clr", v, 16'h0010);
        // Masked event stays silent until unmasked, then clears by writing one
        wreg(`FWX_H_MASK, 16'h0000);
        wreg(`FWX_H_CMD, 16'hA101);
        cyc = 0;
        do begin
            rreg(`FWX_H_IRQ);
            cyc++;
        end while (v[1] !== 1'h1 && cyc < 500);
        chk("masked", {v[1], irq, 14'h0}, 16'h8000);
        wreg(`FWX_H_MASK, 16'h0003);
        #1 chk("unmasked", {15'h0, irq}, 16'h0001);
        wreg(`FWX_H_IRQ, 16'h0002);
        #1 chk("cleared", {15'h0, irq}, 16'h0000);
        end_of_test();
    end
endmodule // tb_four_word_analog_input_exchange
